// File: usbsie_regs.svh
// register offsets, field positions and reset values of the sie status block
`ifndef USBSIE_REGS_SVH
`define USBSIE_REGS_SVH
`define USBSIE_AW           12
`define USBSIE_OFS_STALL    12'h000
`define USBSIE_OFS_SIE_TOKEN_ERROR_STATUS     12'h004
`define USBSIE_OFS_FIFO     12'h008
`define USBSIE_OFS_EPSEL    12'h00C
`define USBSIE_OFS_ADDR     12'h010
`define USBSIE_SIE_TOKEN_ERROR_STATUS_NAKM    7
`define USBSIE_SIE_TOKEN_ERROR_STATUS_ERR_HI  6
`define USBSIE_SIE_TOKEN_ERROR_STATUS_ERR_LO  4
`define USBSIE_SIE_TOKEN_ERROR_STATUS_IN      3
`define USBSIE_SIE_TOKEN_ERROR_STATUS_OUT     2
`define USBSIE_SIE_TOKEN_ERROR_STATUS_FERR    1
`define USBSIE_SIE_TOKEN_ERROR_STATUS_AMODE   0
`define USBSIE_FIFO_ZERO_LENGTH_FLAG    7
`define USBSIE_FIFO_READY   6
`define USBSIE_FIFO_SETUP   5
`define USBSIE_FIFO_VSEL    4
`define USBSIE_FIFO_CLEAR   2
`define USBSIE_FIFO_DIR     1
`define USBSIE_FIFO_REQ     0
`define USBSIE_ADDR_HI      7
`define USBSIE_ADDR_LO      1
`define USBSIE_ADDR_WAKE    0
`define USBSIE_ERR_NONE     3'h0
`define USBSIE_ERR_PID      3'h4
`define USBSIE_ERR_STUFF    3'h5
`define USBSIE_ERR_CRC      3'h6
`define USBSIE_ERR_NORESP   3'h7
`define USBSIE_RST_STALL    7'h00
`define USBSIE_RST_ADDR     7'h00
`define USBSIE_RST_EP       3'h0
`endif

// File: usbsie_pkg.sv
// types shared by the sie status block and its surroundings
package usbsie_pkg;
    typedef enum logic [1:0] {TOK_NONE, TOK_IN, TOK_OUT, TOK_SETUP} usbsie_tok_e;
    typedef logic [2:0] usbsie_ep_t;
    // one cycle event strobes from the serial engine, same clock
    typedef struct packed {
        logic        bus_reset;
        logic        tok_valid;
        usbsie_tok_e tok_kind;
        usbsie_ep_t  tok_ep;
        logic        out_zero_len;
        logic        err_valid;
        logic [2:0]  err_code;
        logic        fifo_err;
        logic        nak_sent;
        usbsie_ep_t  nak_ep;
        logic        in_acked;
        logic        setup_stored;
    } usbsie_evt_s;
endpackage

// File: usbsie_status.sv
// sie status, error, address update and fifo access control with apb registers
`timescale 1ns/10ps
`include "usbsie_regs.svh"
// Notes on behaviour
// - out stall bits 7..1, bus reset clears
// - nak mask blocks nak endpoint interrupt
// - error code top bit zero means none
// - engine writes error code, firmware clears
// - in bit shows current token is in
// - out bit set except zero length out
// - out bit cleared by firmware or setup
// - fifo access error sticky, firmware clears
// - mode zero: new address used at once
// - mode one: switch after in data read
// - zero length flag, setup clears it
// - ready bit shows selected fifo ready
// - setup packet flag set by hardware
// - clear bit rising gives one pulse to empty selected fifo
// - direction zero read, one write
// - write ends on direction one to zero
// - read ends on direction zero to one
// - request high claims fifo, grant gated
// - endpoint select picks fifo zero..seven
// - seven bit address in upper bits
module usbsie_status (
    input  wire logic                     CLK_SYS_IN,
    input  wire logic                     ARST_N_IN,
    input  wire logic                     PSEL_IN,
    input  wire logic                     PENABLE_IN,
    input  wire logic                     PWRITE_IN,
    input  wire logic [`USBSIE_AW-1:0]    PADDR_IN,
    input  wire logic [31:0]              PWDATA_IN,
    output logic      [31:0]              PRDATA_OUT,
    output logic                          PREADY_OUT,
    output logic                          PSLVERR_OUT,
    input  wire usbsie_pkg::usbsie_evt_s  SIE_EVT_IN,
    input  wire logic [7:0]               FIFO_READY_IN,
    input  wire logic [7:0]               EP_INT_EN_IN,
    output logic      [6:0]               DEV_ADDR_OUT,
    output logic                          WAKE_EN_OUT,
    output logic                          VSEL_OUT,
    output logic      [7:0]               OUT_STALL_OUT,
    output logic                          STALL_HS_OUT,
    output logic      [7:0]               NAK_IRQ_OUT,
    output usbsie_pkg::usbsie_ep_t        FIFO_EP_OUT,
    output logic                          FIFO_REQ_OUT,
    output logic                          FIFO_GRANT_OUT,
    output logic                          FIFO_DIR_OUT,
    output logic                          FIFO_CLEAR_OUT,
    output logic                          XFER_END_OUT
);
    import usbsie_pkg::*;

    // one hot endpoint mask, used by interrupt and stall paths
    function automatic logic [7:0] ep_onehot(input usbsie_ep_t ep);
        ep_onehot = 8'h01 << ep;
    endfunction

    // ************************************************************
    // apb slave
    // ************************************************************
    logic        acc;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    logic        hit;
    logic        wr_en;
    logic        wr_stall;
    logic        wr_sie_token_error_status;
    logic        wr_fifo;
    logic        wr_epsel;
    logic        wr_addr;

    // one wait state keeps pready and prdata straight from flops
    assign acc      = PSEL_IN && PENABLE_IN;
    assign wr_en    = acc && pready_r && PWRITE_IN;
    assign wr_stall = wr_en && (PADDR_IN == `USBSIE_OFS_STALL);
    assign wr_sie_token_error_status  = wr_en && (PADDR_IN == `USBSIE_OFS_SIE_TOKEN_ERROR_STATUS);
    assign wr_fifo  = wr_en && (PADDR_IN == `USBSIE_OFS_FIFO);
    assign wr_epsel = wr_en && (PADDR_IN == `USBSIE_OFS_EPSEL);
    assign wr_addr  = wr_en && (PADDR_IN == `USBSIE_OFS_ADDR);

    // handshake flops
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !hit;
            if (acc && !pready_r) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // ************************************************************
    // register state
    // ************************************************************
    logic [6:0]  stall_r;
    logic        nak_mask_r;
    logic [2:0]  err_r;
    logic        in_r;
    logic        out_r;
    logic        ferr_r;
    logic        amode_r;
    logic        zero_length_flag_r;
    logic        setup_flag_r;
    logic        vsel_r;
    logic        clear_r;
    logic        dir_r;
    logic        req_r;
    usbsie_ep_t  eps_r;
    logic [6:0]  addr_reg_r;
    logic        wake_r;
    logic [6:0]  active_addr_r;
    logic        tok_in;
    logic        tok_out;
    logic        tok_setup;

    assign tok_in    = SIE_EVT_IN.tok_valid && (SIE_EVT_IN.tok_kind == TOK_IN);
    assign tok_out   = SIE_EVT_IN.tok_valid && (SIE_EVT_IN.tok_kind == TOK_OUT);
    assign tok_setup = SIE_EVT_IN.tok_valid && (SIE_EVT_IN.tok_kind == TOK_SETUP);

    // stall bits are firmware owned; a bus reset outranks a same cycle write
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            stall_r <= `USBSIE_RST_STALL;
        end else if (SIE_EVT_IN.bus_reset) begin
            stall_r <= `USBSIE_RST_STALL;
        end else if (wr_stall) begin
            stall_r <= PWDATA_IN[7:1];
        end
    end

    // error code: an engine report wins over a firmware clear
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            err_r <= `USBSIE_ERR_NONE;
        end else if (SIE_EVT_IN.err_valid) begin
            err_r <= SIE_EVT_IN.err_code;
        end else if (wr_sie_token_error_status) begin
            err_r <= PWDATA_IN[`USBSIE_SIE_TOKEN_ERROR_STATUS_ERR_HI:`USBSIE_SIE_TOKEN_ERROR_STATUS_ERR_LO];
        end
    end

    // in bit follows every token, not sticky
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            in_r <= 1'b0;
        end else if (SIE_EVT_IN.bus_reset) begin
            in_r <= 1'b0;
        end else if (SIE_EVT_IN.tok_valid) begin
            in_r <= tok_in;
        end
    end

    // out bit: data out sets, setup or firmware clears, set wins
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            out_r <= 1'b0;
        end else if (tok_out && !SIE_EVT_IN.out_zero_len) begin
            out_r <= 1'b1;
        end else if (tok_setup) begin
            out_r <= 1'b0;
        end else if (wr_sie_token_error_status) begin
            out_r <= PWDATA_IN[`USBSIE_SIE_TOKEN_ERROR_STATUS_OUT];
        end
    end

    // fifo access error, sticky until firmware writes zero
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ferr_r <= 1'b0;
        end else if (SIE_EVT_IN.fifo_err) begin
            ferr_r <= 1'b1;
        end else if (wr_sie_token_error_status) begin
            ferr_r <= PWDATA_IN[`USBSIE_SIE_TOKEN_ERROR_STATUS_FERR];
        end
    end

    // plain control bits of the status register
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            nak_mask_r <= 1'b0;
            amode_r    <= 1'b0;
        end else if (wr_sie_token_error_status) begin
            nak_mask_r <= PWDATA_IN[`USBSIE_SIE_TOKEN_ERROR_STATUS_NAKM];
            amode_r    <= PWDATA_IN[`USBSIE_SIE_TOKEN_ERROR_STATUS_AMODE];
        end
    end

    // zero length flag: write zero clears, setup clears, packet sets
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            zero_length_flag_r <= 1'b0;
        end else if (tok_out && SIE_EVT_IN.out_zero_len) begin
            zero_length_flag_r <= 1'b1;
        end else if (tok_setup) begin
            zero_length_flag_r <= 1'b0;
        end else if (wr_fifo && !PWDATA_IN[`USBSIE_FIFO_ZERO_LENGTH_FLAG]) begin
            zero_length_flag_r <= 1'b0;
        end
    end

    // setup packet flag, set wins over firmware write
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            setup_flag_r <= 1'b0;
        end else if (SIE_EVT_IN.setup_stored) begin
            setup_flag_r <= 1'b1;
        end else if (wr_fifo) begin
            setup_flag_r <= PWDATA_IN[`USBSIE_FIFO_SETUP];
        end
    end

    // fifo access control bits written by firmware
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            vsel_r  <= 1'b0;
            clear_r <= 1'b0;
            dir_r   <= 1'b0;
            req_r   <= 1'b0;
        end else if (wr_fifo) begin
            vsel_r  <= PWDATA_IN[`USBSIE_FIFO_VSEL];
            clear_r <= PWDATA_IN[`USBSIE_FIFO_CLEAR];
            dir_r   <= PWDATA_IN[`USBSIE_FIFO_DIR];
            req_r   <= PWDATA_IN[`USBSIE_FIFO_REQ];
        end
    end

    // endpoint select
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            eps_r <= `USBSIE_RST_EP;
        end else if (wr_epsel) begin
            eps_r <= PWDATA_IN[2:0];
        end
    end

    // stored address and wake enable
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            addr_reg_r <= `USBSIE_RST_ADDR;
            wake_r     <= 1'b0;
        end else if (wr_addr) begin
            addr_reg_r <= PWDATA_IN[`USBSIE_ADDR_HI:`USBSIE_ADDR_LO];
            wake_r     <= PWDATA_IN[`USBSIE_ADDR_WAKE];
        end
    end

    // active address; deferred mode waits for the host to take the in data
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            active_addr_r <= `USBSIE_RST_ADDR;
        end else if (SIE_EVT_IN.bus_reset) begin
            active_addr_r <= `USBSIE_RST_ADDR;
        end else if (wr_addr && !amode_r) begin
            active_addr_r <= PWDATA_IN[`USBSIE_ADDR_HI:`USBSIE_ADDR_LO];
        end else if (amode_r && SIE_EVT_IN.in_acked) begin
            active_addr_r <= addr_reg_r;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (PADDR_IN)
            `USBSIE_OFS_STALL: begin
                rd_mux[7:0] = {stall_r, 1'b0};
            end
            `USBSIE_OFS_SIE_TOKEN_ERROR_STATUS: begin
                rd_mux[7:0] = {nak_mask_r, err_r, in_r, out_r, ferr_r, amode_r};
            end
            `USBSIE_OFS_FIFO: begin
                rd_mux[7:0] = {zero_length_flag_r, FIFO_READY_IN[eps_r], setup_flag_r, vsel_r,
                               1'b0, clear_r, dir_r, req_r};
            end
            `USBSIE_OFS_EPSEL: begin
                rd_mux[2:0] = eps_r;
            end
            `USBSIE_OFS_ADDR: begin
                rd_mux[7:0] = {addr_reg_r, wake_r};
            end
            default: begin
                hit = 1'b0; // unmapped reads zero with pslverr
            end
        endcase
    end

    // ************************************************************
    // link side outputs
    // ************************************************************
    logic       stall_hs_r;
    logic [7:0] nak_irq_r;
    logic       clear_q_r;
    logic       fifo_clear_r;
    logic       dir_q_r;
    logic       req_q_r;
    logic       xfer_end_r;
    logic       grant_r;

    // stall handshake for out tokens to a stalled endpoint; ep0 never stalls here
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            stall_hs_r <= 1'b0;
        end else begin
            stall_hs_r <= tok_out && |(ep_onehot(SIE_EVT_IN.tok_ep) & {stall_r, 1'b0});
        end
    end

    // nak interrupt, gated by mask and endpoint enable
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            nak_irq_r <= 8'h00;
        end else if (SIE_EVT_IN.nak_sent && !nak_mask_r) begin
            nak_irq_r <= ep_onehot(SIE_EVT_IN.nak_ep) & EP_INT_EN_IN;
        end else begin
            nak_irq_r <= 8'h00;
        end
    end

    // edge detect so a long clear level still gives one flush
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            clear_q_r    <= 1'b0;
            fifo_clear_r <= 1'b0;
        end else begin
            clear_q_r    <= clear_r;
            fifo_clear_r <= clear_r && !clear_q_r;
        end
    end

    // a direction flip under a request already held ends a transfer;
    // raising request and direction in one write only starts one
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            dir_q_r    <= 1'b0;
            req_q_r    <= 1'b0;
            xfer_end_r <= 1'b0;
        end else begin
            dir_q_r    <= dir_r;
            req_q_r    <= req_r;
            xfer_end_r <= req_r && req_q_r && (dir_r != dir_q_r);
        end
    end

    // grant only while requested and the selected fifo is ready
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            grant_r <= 1'b0;
        end else begin
            grant_r <= req_r && FIFO_READY_IN[eps_r];
        end
    end

    assign PRDATA_OUT     = prdata_r;
    assign PREADY_OUT     = pready_r;
    assign PSLVERR_OUT    = pslverr_r;
    assign DEV_ADDR_OUT   = active_addr_r;
    assign WAKE_EN_OUT    = wake_r;
    assign VSEL_OUT       = vsel_r;
    assign OUT_STALL_OUT  = {stall_r, 1'b0};
    assign STALL_HS_OUT   = stall_hs_r;
    assign NAK_IRQ_OUT    = nak_irq_r;
    assign FIFO_EP_OUT    = eps_r;
    assign FIFO_REQ_OUT   = req_r;
    assign FIFO_GRANT_OUT = grant_r;
    assign FIFO_DIR_OUT   = dir_r;
    assign FIFO_CLEAR_OUT = fifo_clear_r;
    assign XFER_END_OUT   = xfer_end_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    sequence s_defer_write;
        wr_addr && amode_r && !SIE_EVT_IN.in_acked;
    endsequence
    sequence s_clear_rise;
        wr_fifo && PWDATA_IN[`USBSIE_FIFO_CLEAR] && !clear_r;
    endsequence

    a_stall_bus_reset: assert property (SIE_EVT_IN.bus_reset |=> OUT_STALL_OUT == 8'h00)
        else $error("stall bits survived bus reset");
    a_nak_masked: assert property (nak_mask_r |=> NAK_IRQ_OUT == 8'h00)
        else $error("nak interrupt while masked");
    a_nak_raised: assert property (SIE_EVT_IN.nak_sent && !nak_mask_r
        |=> NAK_IRQ_OUT == (ep_onehot($past(SIE_EVT_IN.nak_ep)) & $past(EP_INT_EN_IN)))
        else $error("nak interrupt wrong");
    a_err_capture: assert property (SIE_EVT_IN.err_valid |=> err_r == $past(SIE_EVT_IN.err_code))
        else $error("error code not captured");
    a_in_track: assert property (SIE_EVT_IN.tok_valid && !SIE_EVT_IN.bus_reset
        |=> in_r == $past(tok_in))
        else $error("in bit wrong");
    a_out_set: assert property (tok_out && !SIE_EVT_IN.out_zero_len |=> out_r)
        else $error("out bit not set");
    a_out_zero_keep: assert property (tok_out && SIE_EVT_IN.out_zero_len && !wr_sie_token_error_status
        |=> $stable(out_r) && zero_length_flag_r)
        else $error("zero length out handled wrong");
    a_setup_clears: assert property (tok_setup && !wr_fifo |=> !out_r && !zero_length_flag_r)
        else $error("setup did not clear flags");
    a_ferr_sticky: assert property (SIE_EVT_IN.fifo_err |=> ferr_r)
        else $error("fifo error lost");
    a_addr_immed: assert property (wr_addr && !amode_r && !SIE_EVT_IN.bus_reset
        |=> DEV_ADDR_OUT == $past(PWDATA_IN[`USBSIE_ADDR_HI:`USBSIE_ADDR_LO]))
        else $error("address not taken at once");
    a_addr_defer: assert property ((s_defer_write and !SIE_EVT_IN.bus_reset)
        |=> $stable(DEV_ADDR_OUT))
        else $error("deferred address switched early");
    a_clear_once: assert property (s_clear_rise ##1 1'b1 |=> FIFO_CLEAR_OUT ##1 !FIFO_CLEAR_OUT)
        else $error("clear pulse wrong");
    a_grant_gate: assert property (FIFO_GRANT_OUT |-> $past(req_r) && $past(FIFO_READY_IN[eps_r]))
        else $error("grant without request");
    a_stall_answer: assert property (tok_out && SIE_EVT_IN.tok_ep != 3'h0 && !SIE_EVT_IN.bus_reset
        && stall_r[SIE_EVT_IN.tok_ep - 3'h1] |=> STALL_HS_OUT)
        else $error("stalled out not answered");
    a_start_no_end: assert property ($rose(req_r) |=> !XFER_END_OUT)
        else $error("transfer start flagged as end");
endmodule

// File: usbsie_sie_model.sv
// serial engine model: one-cycle event strobes and per-endpoint fifo ready levels
`timescale 1ns/10ps
module usbsie_sie_model
    import usbsie_pkg::*;
(
    input  wire logic        clk_in,
    output usbsie_evt_s      evt_out,
    output logic [7:0]       ready_out
);
    // quiet at time zero so the block never sees a stray event
    initial begin
        evt_out = '0;
        ready_out = 8'h00;
    end
    // k: 0 reset 1 ferr 2 in-ack 3 setup data 4 error 5 nak 6 in 7 out 8 setup
    task automatic fire(input int k, input logic [2:0] v, input logic z);
        usbsie_evt_s e;
        e = '0;
        case (k)
            0: e.bus_reset = 1'b1;
            1: e.fifo_err = 1'b1;
            2: e.in_acked = 1'b1;
            3: e.setup_stored = 1'b1;
            4: e.err_valid = 1'b1;
            5: e.nak_sent = 1'b1;
            default: begin
                e.tok_valid = 1'b1;
                e.tok_kind = (k == 6) ? TOK_IN : (k == 7) ? TOK_OUT : TOK_SETUP;
            end
        endcase
        e.err_code = v;
        e.nak_ep = v;
        e.tok_ep = v;
        e.out_zero_len = z;
        // launched after an edge and dropped after the next, like the real engine
        @(posedge clk_in);
        evt_out <= e;
        @(posedge clk_in);
        evt_out <= '0;
    endtask
    task automatic set_ready(input logic [7:0] r);
        @(posedge clk_in);
        ready_out <= r;
    endtask
endmodule

// File: usbsie_status_test.sv
// self-checking bench for the sie status block: apb tasks, event model, pulse counters
`timescale 1ns/10ps
`include "usbsie_regs.svh"
module usbsie_status_test;
    import usbsie_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [7:0]  ready, int_en, stall, nak, nak_acc = 8'h00;
    logic [6:0]  dev_addr;
    logic        wake, vsel, stall_hs, req, grant, dir, clr, xend;
    usbsie_ep_t  fifo_ep;
    usbsie_evt_s evt;
    int          fail_count = 0, tests_run = 0;
    int          n_stall = 0, n_nak = 0, n_xend = 0, n_clr = 0;

    usbsie_status dut (
        .CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SIE_EVT_IN(evt),
        .FIFO_READY_IN(ready), .EP_INT_EN_IN(int_en), .DEV_ADDR_OUT(dev_addr),
        .WAKE_EN_OUT(wake), .VSEL_OUT(vsel), .OUT_STALL_OUT(stall),
        .STALL_HS_OUT(stall_hs), .NAK_IRQ_OUT(nak), .FIFO_EP_OUT(fifo_ep),
        .FIFO_REQ_OUT(req), .FIFO_GRANT_OUT(grant), .FIFO_DIR_OUT(dir),
        .FIFO_CLEAR_OUT(clr), .XFER_END_OUT(xend));
    usbsie_sie_model sie (.clk_in(clk), .evt_out(evt), .ready_out(ready));

    always #4 clk = ~clk;
    // count one-cycle pulses so a doubled or missing pulse shows up
    always @(posedge clk) begin
        n_stall <= n_stall + int'(stall_hs === 1'b1);
        n_xend <= n_xend + int'(xend === 1'b1);
        n_clr <= n_clr + int'(clr === 1'b1);
        n_nak <= n_nak + int'(nak !== 8'h00);
        nak_acc <= nak_acc | nak;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // apb master: holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: apb transfer timed out", $time);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(rdata, e);
    endtask
    // one edge of slack, then look at settled outputs
    task automatic tick();
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // a hung handshake must not stall the run
    initial begin
        #100000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        int_en = 8'h20;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(12'(i * 4), 32'h0);
        wr(`USBSIE_OFS_STALL, 8'hFF);
        rchk(`USBSIE_OFS_STALL, 32'hFE);
        chk(stall, 32'hFE);
        apb(1'b0, 12'h0FC, 8'h00);
        chk({rdata[30:0], rerr}, 32'h1);
        sie.fire(7, 3'h2, 1'b0);
        sie.fire(7, 3'h0, 1'b0);
        tick();
        chk(n_stall, 1);
        sie.fire(0, 3'h0, 1'b0);
        rchk(`USBSIE_OFS_STALL, 32'h0);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h00);
        for (int c = 4; c < 8; c++) begin
            sie.fire(4, 3'(c), 1'b0);
            rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'(c << 4));
            wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h00);
        end
        sie.fire(1, 3'h0, 1'b0);
        rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'h02);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h00);
        rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'h00);
        sie.fire(6, 3'h1, 1'b0);
        rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'h08);
        sie.fire(7, 3'h1, 1'b0);
        rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'h04);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h00);
        sie.fire(7, 3'h1, 1'b1);
        rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'h00);
        rchk(`USBSIE_OFS_FIFO, 32'h80);
        sie.fire(7, 3'h1, 1'b0);
        sie.fire(8, 3'h0, 1'b0);
        rchk(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 32'h00);
        rchk(`USBSIE_OFS_FIFO, 32'h00);
        sie.fire(3, 3'h0, 1'b0);
        rchk(`USBSIE_OFS_FIFO, 32'h20);
        wr(`USBSIE_OFS_FIFO, 8'h00);
        rchk(`USBSIE_OFS_FIFO, 32'h00);
        sie.fire(5, 3'h5, 1'b0);
        sie.fire(5, 3'h4, 1'b0);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h80);
        sie.fire(5, 3'h5, 1'b0);
        tick();
        chk({n_nak[23:0], nak_acc}, 32'h120);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h00);
        wr(`USBSIE_OFS_ADDR, 8'h0B);
        tick();
        chk({wake, dev_addr}, 32'h85);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h01);
        wr(`USBSIE_OFS_ADDR, 8'h14);
        tick();
        chk(dev_addr, 32'h05);
        sie.fire(2, 3'h0, 1'b0);
        tick();
        chk(dev_addr, 32'h0A);
        sie.fire(8, 3'h0, 1'b0);
        wr(`USBSIE_OFS_SIE_TOKEN_ERROR_STATUS, 8'h00);
        wr(`USBSIE_OFS_ADDR, 8'h06);
        tick();
        chk(dev_addr, 32'h03);
        sie.set_ready(8'h08);
        wr(`USBSIE_OFS_EPSEL, 8'h03);
        wr(`USBSIE_OFS_FIFO, 8'h03);
        tick();
        chk({fifo_ep, req, grant, dir}, 32'h1F);
        rchk(`USBSIE_OFS_FIFO, 32'h43);
        wr(`USBSIE_OFS_FIFO, 8'h01);
        wr(`USBSIE_OFS_FIFO, 8'h00);
        tick();
        chk({n_xend[7:0], grant}, 32'h2);
        wr(`USBSIE_OFS_FIFO, 8'h01);
        wr(`USBSIE_OFS_FIFO, 8'h03);
        sie.set_ready(8'h00);
        tick();
        chk(grant, 32'h0);
        wr(`USBSIE_OFS_FIFO, 8'h02);
        wr(`USBSIE_OFS_FIFO, 8'h04);
        wr(`USBSIE_OFS_FIFO, 8'h04);
        wr(`USBSIE_OFS_FIFO, 8'h00);
        wr(`USBSIE_OFS_FIFO, 8'h04);
        wr(`USBSIE_OFS_FIFO, 8'h00);
        tick();
        chk({n_clr[7:0], n_xend[7:0]}, 32'h0202);
        wr(`USBSIE_OFS_FIFO, 8'h10);
        tick();
        chk(vsel, 32'h1);
        rchk(`USBSIE_OFS_FIFO, 32'h10);
        results();
    end
endmodule
